// ---- design/chbp_pkg.sv ----
// Purpose: shared constants and types of the host bus slave port
// Assumes: one 100 MHz clock, host inputs already synchronous
// Notes: target map uses the upper address bits of the 12-bit word address
package chbp_pkg;
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    localparam int FIFO_AW = 7; // 128 words of 32 bits, one 4-Kbit buffer
    // target decode on addr[11:10]
    localparam logic [1:0] TGT_IFIFO = 2'h0;
    localparam logic [1:0] TGT_OFIFO = 2'h1;
    localparam logic [1:0] TGT_IFREG = 2'h2;
    localparam logic [1:0] TGT_UNIT = 2'h3;
    // wait cycles before a data beat
    localparam logic [3:0] WAIT_FIXED = 4'h2;
    localparam logic [3:0] WAIT_UNIT = 4'h4;
    localparam logic [3:0] WAIT_BURST_FIRST = 4'h2;
    localparam logic [3:0] WAIT_BURST_NEXT = 4'h0;
    localparam logic [DATA_W-1:0] RD_RESET = 32'h0000_0000;
    localparam int IFREG_N = 4;

    typedef enum logic [1:0] {
        CHBP_IDLE = 2'b00,
        CHBP_WAIT = 2'b01,
        CHBP_BEAT = 2'b11
    } chbp_state_t;

    // request as taken on the starting edge
    typedef struct packed {
        logic rd;
        logic burst;
        logic [ADDR_W-1:0] addr;
    } chbp_req_t;

    // access toward internal targets
    typedef struct packed {
        logic wr;
        logic rd;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } chbp_acc_t;

    function automatic logic [1:0] chbp_target(input logic [ADDR_W-1:0] a);
        return a[ADDR_W-1:ADDR_W-2];
    endfunction

    function automatic logic chbp_fixed(input logic [ADDR_W-1:0] a);
        return chbp_target(a) != TGT_UNIT;
    endfunction
endpackage

// ---- design/chbp_mem.sv ----
// Purpose: small word memory with registered read data
// Assumes: single clock, one write and one read port
// Notes: contents are not reset
`timescale 1ns/100ps
module chbp_mem
    import chbp_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic we_i,
    input wire logic [FIFO_AW-1:0] waddr_i,
    input wire logic [DATA_W-1:0] wdata_i,
    input wire logic [FIFO_AW-1:0] raddr_i,
    output logic [DATA_W-1:0] rdata_o
);
    logic [DATA_W-1:0] mem [0:(1<<FIFO_AW)-1];

    ////////////////////////////////////////////////////////////////////////
    // write port
    always_ff @(posedge clk_sys_i) begin
        if (we_i) begin
            mem[waddr_i] <= wdata_i;
        end
    end

    // registered read keeps the data path timing fixed
    always_ff @(posedge clk_sys_i) begin
        rdata_o <= mem[raddr_i];
    end
endmodule

// ---- design/chbp_ifreg.sv ----
// Purpose: small bank of bus-interface registers
// Assumes: accesses arrive as one-cycle strobes
// Notes: index from the low address bits; read data registered
`timescale 1ns/100ps
module chbp_ifreg
    import chbp_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic sys_rst_i,
    input wire chbp_acc_t acc_i,
    output logic [DATA_W-1:0] rdata_o
);
    logic [DATA_W-1:0] regs [IFREG_N];

    ////////////////////////////////////////////////////////////////////////
    // one register per slot, generated
    for (genvar g = 0; g < IFREG_N; g++) begin : g_reg
        always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
            if (sys_rst_i) begin
                regs[g] <= RD_RESET;
            end else if (acc_i.wr && acc_i.addr[1:0] == 2'(g)) begin
                regs[g] <= acc_i.wdata;
            end
        end
    end

    // read data out of a flop
    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            rdata_o <= RD_RESET;
        end else begin
            rdata_o <= regs[acc_i.addr[1:0]];
        end
    end
endmodule

// ---- design/chbp_port.sv ----
// Purpose: 32-bit synchronous host bus slave port, two host protocols
// Assumes: host inputs synchronous to clk_sys_i; mode_sel_i static
// Notes: input fifo write, output fifo read, interface regs, unit port
// Functional notes
// - host masters every cycle; this port only answers as slave
// - first mode starts on edge with transfer start and chip select low
// - read/write line taken on the starting edge sets direction
// - address decoded on the starting edge selects the target
// - first mode holds acknowledge high during target wait cycles
// - first mode drives acknowledge low in the valid data cycle
// - second mode starts on edge with chip select low, no start needed
// - second mode drives wait high for the access's wait cycles
// - data-valid strobe marks beat: read data driven, write data captured
// - fifo and interface-register accesses take fixed cycle counts
// - fixed accesses in second mode transfer without data-valid strobe
// - bursts only in second mode, input fifo writes or output fifo reads
// - burst: two wait cycles before first beat, none before later ones
// - mode select high picks second mode, low picks first
// - data-valid strobe ignored in first mode
// - read/write high means read, low means write
`timescale 1ns/100ps
module chbp_port
    import chbp_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic sys_rst_i,
    input wire logic mode_sel_i,
    input wire logic chip_sel_n_i,
    input wire logic transfer_start_n_i,
    input wire logic read_write_i,
    input wire logic burst_n_i,
    input wire logic host_data_valid_n_i,
    input wire logic [ADDR_W-1:0] addr_i,
    input wire logic [DATA_W-1:0] data_i,
    output logic [DATA_W-1:0] data_o,
    output logic data_oe_o,
    output logic transfer_ack_n_o,
    output logic host_wait_out_alt_o,
    output logic unit_wr_o,
    output logic unit_rd_o,
    output logic [ADDR_W-1:0] unit_addr_o,
    output logic [DATA_W-1:0] unit_wdata_o,
    input wire logic [DATA_W-1:0] unit_rdata_i,
    output logic ififo_valid_o,
    output logic [DATA_W-1:0] ififo_data_o,
    output logic [FIFO_AW:0] ififo_level_o,
    input wire logic ififo_pop_i,
    input wire logic [DATA_W-1:0] ofifo_data_i,
    input wire logic ofifo_push_i,
    output logic [FIFO_AW:0] ofifo_level_o
);
    chbp_state_t state;
    chbp_req_t req;
    chbp_acc_t ifacc;
    logic [3:0] wcnt;
    logic start;
    logic beat;
    logic burst_on;
    logic [DATA_W-1:0] rd_mux;
    logic [DATA_W-1:0] ifreg_rdata;
    logic [DATA_W-1:0] ofifo_rdata;
    logic [DATA_W-1:0] ififo_rdata;
    logic [FIFO_AW:0] iw_ptr, ir_ptr, ow_ptr, or_ptr;
    logic ififo_we;
    logic ofifo_re;

    ////////////////////////////////////////////////////////////////////////
    // cycle start: the host is always master, nothing starts on our own
    assign start = (state == CHBP_IDLE) && !chip_sel_n_i &&
                   (mode_sel_i || !transfer_start_n_i);

    // burst only honoured for the legal fifo directions in second mode
    assign burst_on = req.burst && !burst_n_i && !chip_sel_n_i &&
                      ((req.rd && chbp_target(req.addr) == TGT_OFIFO) ||
                       (!req.rd && chbp_target(req.addr) == TGT_IFIFO));

    // data beat: fixed targets ignore the strobe, others in mode two wait for it
    // a deselect ends a burst with no extra beat, so nothing lands after it
    assign beat = (state == CHBP_BEAT) && !chip_sel_n_i &&
                  (!mode_sel_i || chbp_fixed(req.addr) || !host_data_valid_n_i);

    ////////////////////////////////////////////////////////////////////////
    // request capture on the starting edge
    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            req <= '0;
        end else if (start) begin
            req.rd <= read_write_i;
            req.addr <= addr_i;
            req.burst <= mode_sel_i && !burst_n_i;
        end else if (beat && burst_on) begin
            req.addr <= req.addr; // fifo targets keep one address
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // state machine and wait counter; fixed targets get constant counts
    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            state <= CHBP_IDLE;
            wcnt <= '0;
        end else begin
            unique case (state)
                CHBP_IDLE: begin
                    if (start) begin
                        state <= CHBP_WAIT;
                        if (mode_sel_i && !burst_n_i) begin
                            wcnt <= WAIT_BURST_FIRST;
                        end else if (chbp_fixed(addr_i)) begin
                            wcnt <= WAIT_FIXED;
                        end else begin
                            wcnt <= WAIT_UNIT;
                        end
                    end
                end
                CHBP_WAIT: begin
                    // count the wait cycles, then present the beat
                    if (wcnt <= 4'h1) begin
                        state <= CHBP_BEAT;
                        wcnt <= '0;
                    end else begin
                        wcnt <= wcnt - 4'h1;
                    end
                end
                CHBP_BEAT: begin
                    // later burst beats follow with no wait
                    if (beat && !burst_on) begin
                        state <= CHBP_IDLE;
                    end else if (chip_sel_n_i) begin
                        state <= CHBP_IDLE;
                    end
                end
                default: state <= CHBP_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // handshake outputs, inactive unless busy; only the start term needs chip select
    always_comb begin
        transfer_ack_n_o = 1'b1;
        host_wait_out_alt_o = 1'b0;
        if (!mode_sel_i) begin
            transfer_ack_n_o = !(state == CHBP_BEAT);
        end else begin
            host_wait_out_alt_o = (state == CHBP_WAIT) || start;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // internal target strobes; write data captured on the beat
    assign ififo_we = beat && !req.rd && chbp_target(req.addr) == TGT_IFIFO &&
                      (ififo_level_o != 8'(1 << FIFO_AW));
    assign ofifo_re = beat && req.rd && chbp_target(req.addr) == TGT_OFIFO &&
                      (ofifo_level_o != '0);

    always_comb begin
        ifacc = '0;
        ifacc.addr = req.addr;
        ifacc.wdata = data_i;
        ifacc.wr = beat && !req.rd && chbp_target(req.addr) == TGT_IFREG;
        ifacc.rd = beat && req.rd && chbp_target(req.addr) == TGT_IFREG;
    end

    // unit accesses go out as one-cycle strobes with registered data
    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            unit_wr_o <= 1'b0;
            unit_rd_o <= 1'b0;
            unit_addr_o <= '0;
            unit_wdata_o <= RD_RESET;
        end else begin
            unit_wr_o <= beat && !req.rd && chbp_target(req.addr) == TGT_UNIT;
            unit_rd_o <= start && read_write_i && chbp_target(addr_i) == TGT_UNIT;
            unit_addr_o <= start ? addr_i : unit_addr_o;
            unit_wdata_o <= data_i;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // fifo pointers: host fills input fifo, engine fills output fifo
    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            iw_ptr <= '0;
            ir_ptr <= '0;
            ow_ptr <= '0;
            or_ptr <= '0;
        end else begin
            iw_ptr <= iw_ptr + 8'(ififo_we);
            ir_ptr <= ir_ptr + 8'(ififo_pop_i && ififo_valid_o);
            ow_ptr <= ow_ptr + 8'(ofifo_push_i && ofifo_level_o != 8'(1 << FIFO_AW));
            or_ptr <= or_ptr + 8'(ofifo_re);
        end
    end
    assign ififo_level_o = iw_ptr - ir_ptr;
    assign ofifo_level_o = ow_ptr - or_ptr;
    assign ififo_valid_o = ififo_level_o != '0;
    assign ififo_data_o = ififo_rdata; // head word, valid one cycle after a pop

    chbp_mem u_ififo (
        .clk_sys_i(clk_sys_i),
        .we_i(ififo_we),
        .waddr_i(iw_ptr[FIFO_AW-1:0]),
        .wdata_i(data_i),
        .raddr_i(ir_ptr[FIFO_AW-1:0] + 7'(ififo_pop_i && ififo_valid_o)),
        .rdata_o(ififo_rdata)
    );

    // the read pointer looks one ahead so a burst read has no bubble
    chbp_mem u_ofifo (
        .clk_sys_i(clk_sys_i),
        .we_i(ofifo_push_i && ofifo_level_o != 8'(1 << FIFO_AW)),
        .waddr_i(ow_ptr[FIFO_AW-1:0]),
        .wdata_i(ofifo_data_i),
        .raddr_i(or_ptr[FIFO_AW-1:0] + 7'(ofifo_re)),
        .rdata_o(ofifo_rdata)
    );

    chbp_ifreg u_ifreg (
        .clk_sys_i(clk_sys_i),
        .sys_rst_i(sys_rst_i),
        .acc_i(ifacc),
        .rdata_o(ifreg_rdata)
    );

    ////////////////////////////////////////////////////////////////////////
    // read data path; bus driven only during a read beat
    always_comb begin
        unique case (chbp_target(req.addr))
            TGT_IFIFO: rd_mux = RD_RESET;
            TGT_OFIFO: rd_mux = (ofifo_level_o != '0) ? ofifo_rdata : RD_RESET; // empty reads 0
            TGT_IFREG: rd_mux = ifreg_rdata;
            TGT_UNIT: rd_mux = unit_rdata_i;
        endcase
    end

    // combinational select of registered sources keeps the beat aligned
    assign data_o = (state == CHBP_BEAT && req.rd) ? rd_mux : RD_RESET;
    assign data_oe_o = (state == CHBP_BEAT) && req.rd && !chip_sel_n_i;

    ////////////////////////////////////////////////////////////////////////
    // checks
    idle_quiet_a: assert property (
        @(posedge clk_sys_i) disable iff (sys_rst_i)
        (state == CHBP_IDLE) |-> transfer_ack_n_o && !data_oe_o)
        else $error("handshake active while idle");
    ack_mode_a: assert property (
        @(posedge clk_sys_i) disable iff (sys_rst_i)
        mode_sel_i |-> transfer_ack_n_o)
        else $error("acknowledge driven in second mode");
    start1_a: assert property (
        @(posedge clk_sys_i) disable iff (sys_rst_i)
        (state == CHBP_IDLE && !mode_sel_i && transfer_start_n_i) |=> state == CHBP_IDLE)
        else $error("first mode started without transfer start");
    start2_a: assert property (
        @(posedge clk_sys_i) disable iff (sys_rst_i)
        (state == CHBP_IDLE && mode_sel_i && !chip_sel_n_i) |=> state == CHBP_WAIT)
        else $error("second mode did not start on chip select");
    // the beat state is seen on the third edge after the starting edge
    fixed_lat_a: assert property (
        @(posedge clk_sys_i) disable iff (sys_rst_i)
        (start && chbp_fixed(addr_i) && burst_n_i) |-> ##3 state == CHBP_BEAT)
        else $error("fixed access latency wrong");
    unit_lat_a: assert property (
        @(posedge clk_sys_i) disable iff (sys_rst_i)
        (start && !chbp_fixed(addr_i) && burst_n_i) |-> ##5 state == CHBP_BEAT)
        else $error("unit access latency wrong");
    // wait stands in the start cycle and in both burst wait cycles
    burst_wait_a: assert property (
        @(posedge clk_sys_i) disable iff (sys_rst_i)
        (start && mode_sel_i && !burst_n_i) |->
        host_wait_out_alt_o [*3] ##1 !host_wait_out_alt_o)
        else $error("burst first beat wait count wrong");
    ack_low_a: assert property (
        @(posedge clk_sys_i) disable iff (sys_rst_i)
        (!mode_sel_i && state == CHBP_WAIT && wcnt <= 4'h1) |=> !transfer_ack_n_o)
        else $error("acknowledge missing after wait");
    dir_a: assert property (
        @(posedge clk_sys_i) disable iff (sys_rst_i)
        start |=> req.rd == $past(read_write_i))
        else $error("direction not taken at start");
    desel_end_a: assert property (
        @(posedge clk_sys_i) disable iff (sys_rst_i)
        (state == CHBP_BEAT && chip_sel_n_i) |->
        !ififo_we && !ofifo_re ##1 state == CHBP_IDLE)
        else $error("deselect did not end the cycle quietly");
endmodule

// ---- tb/chbp_host.sv ----
// Purpose: host bus master model for the slave port
// Assumes: drives on falling edges, either host mode
// Notes: released lines show inverted values, not the last ones
`timescale 1ns/100ps
module chbp_host
    import chbp_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic ack_n_i,
    input wire logic wait_i,
    input wire logic oe_i,
    input wire logic [DATA_W-1:0] rdata_i,
    output logic mode_o,
    output logic sel_n_o,
    output logic start_n_o,
    output logic rw_o,
    output logic burst_n_o,
    output logic strobe_n_o,
    output logic [ADDR_W-1:0] addr_o,
    output logic [DATA_W-1:0] wdata_o
);
    logic [DATA_W-1:0] wbuf [8];
    logic [DATA_W-1:0] rbuf [8];
    int lat;
    int gaps;

    ////////////////////////////////////////
    // idle bus, nothing selected
    initial begin
        mode_o = 1'b0;
        sel_n_o = 1'b1;
        start_n_o = 1'b1;
        rw_o = 1'b1;
        burst_n_o = 1'b1;
        strobe_n_o = 1'b1;
        addr_o = '0;
        wdata_o = '0;
    end

    // one cycle of 1..8 words; a stalled slave gives up after 20 cycles
    task automatic xfer(input logic mode, input logic rd, input logic [ADDR_W-1:0] a,
                        input int words);
        int n;
        int k;
        logic unit;
        n = 0;
        k = 0;
        gaps = 0;
        lat = 0;
        unit = mode && (a[ADDR_W-1:ADDR_W-2] == TGT_UNIT);
        mode_o = mode; // protocol choice
        @(negedge clk_sys_i);
        sel_n_o = 1'b0; // host masters the cycle
        start_n_o = mode; // start only in first mode
        rw_o = rd;
        burst_n_o = (words == 1); // held for whole burst
        strobe_n_o = mode; // low in first mode, must be ignored
        addr_o = a;
        wdata_o = wbuf[0];
        // answers settle after the rising edge, so they are judged at the falling one
        while (k < words && n < 20) begin
            @(negedge clk_sys_i);
            n++;
            start_n_o = 1'b1;
            wdata_o = wbuf[k];
            if (mode ? !wait_i : !ack_n_i) begin // completes after wait
                if (k == 0) lat = n;
                if (unit) strobe_n_o = 1'b0; // beat strobe, unit only
                if (rd) rbuf[k] = rdata_i;
                if (rd && !oe_i) gaps++;
                k++;
            end else if (k > 0) gaps++;
        end
        @(negedge clk_sys_i);
        sel_n_o = 1'b1;
        burst_n_o = 1'b1;
        strobe_n_o = 1'b1;
        rw_o = !rd;
        addr_o = ~a;
        wdata_o = ~wdata_o;
    endtask
endmodule

// ---- tb/chbp_port_tb.sv ----
// Purpose: self-checking bench for the host bus slave port
// Assumes: host model drives host pins, bench drives the engine side
// Notes: latencies follow the package wait counts
`timescale 1ns/100ps
module chbp_port_tb
    import chbp_pkg::*;
;
    localparam int LFIX = int'(WAIT_FIXED) + 1;
    localparam int LUNIT = int'(WAIT_UNIT) + 1;
    localparam int LBUR = int'(WAIT_BURST_FIRST) + 1;
    logic clk_sys, sys_rst, mode_sel, sel_n, start_n, rw, burst_n, strobe_n;
    logic oe, ack_n, wait_hi, unit_wr, unit_rd, ififo_valid, ififo_pop, ofifo_push;
    logic [ADDR_W-1:0] addr, unit_addr, uw_addr;
    logic [DATA_W-1:0] wdata, rdata, unit_rdata, ififo_data, ofifo_data, unit_wdata, uw_data;
    logic [FIFO_AW:0] ififo_level, ofifo_level;
    int mismatches = 0;
    int total_checks = 0;
    int uw_cnt = 0;
    int ur_cnt = 0;

    chbp_port DUT (.clk_sys_i(clk_sys), .sys_rst_i(sys_rst), .mode_sel_i(mode_sel),
        .chip_sel_n_i(sel_n), .transfer_start_n_i(start_n), .read_write_i(rw),
        .burst_n_i(burst_n), .host_data_valid_n_i(strobe_n), .addr_i(addr), .data_i(wdata),
        .data_o(rdata), .data_oe_o(oe), .transfer_ack_n_o(ack_n), .host_wait_out_alt_o(wait_hi),
        .unit_wr_o(unit_wr), .unit_rd_o(unit_rd), .unit_addr_o(unit_addr),
        .unit_wdata_o(unit_wdata), .unit_rdata_i(unit_rdata), .ififo_valid_o(ififo_valid),
        .ififo_data_o(ififo_data), .ififo_level_o(ififo_level), .ififo_pop_i(ififo_pop),
        .ofifo_data_i(ofifo_data), .ofifo_push_i(ofifo_push), .ofifo_level_o(ofifo_level));
    chbp_host host (.clk_sys_i(clk_sys), .ack_n_i(ack_n), .wait_i(wait_hi), .oe_i(oe),
        .rdata_i(rdata), .mode_o(mode_sel), .sel_n_o(sel_n), .start_n_o(start_n), .rw_o(rw),
        .burst_n_o(burst_n), .strobe_n_o(strobe_n), .addr_o(addr), .wdata_o(wdata));

    ////////////////////////////////////////
    // clock and unit-side strobe capture
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        if (unit_wr === 1'b1) begin
            uw_cnt <= uw_cnt + 1;
            uw_addr <= unit_addr;
            uw_data <= unit_wdata;
        end
        if (unit_rd === 1'b1) ur_cnt <= ur_cnt + 1;
    end

    ////////////////////////////////////////
    // helpers
    task automatic check(input logic ok, input string msg);
        total_checks++;
        if (ok !== 1'b1) begin
            mismatches++;
            $display("[FAIL] %0t %s", $time, msg);
        end
    endtask
    task automatic conclude();
        if (mismatches == 0 && total_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic idle_chk();
        check(ack_n === 1'b1 && wait_hi === 1'b0 && oe === 1'b0, "not idle");
    endtask
    // idle is judged one edge after release, once the deselect has settled
    task automatic run(input logic m, input logic rd, input logic [ADDR_W-1:0] a, input int w,
                       input int exp_lat);
        host.xfer(m, rd, a, w);
        check(host.lat == exp_lat, "latency");
        check(host.gaps == 0, "beat gap");
        @(negedge clk_sys);
        idle_chk();
        @(negedge clk_sys);
    endtask
    task automatic pop_chk(input logic [DATA_W-1:0] exp);
        check(ififo_valid === 1'b1 && ififo_data === exp, "ififo word");
        ififo_pop = 1'b1;
        @(negedge clk_sys);
        ififo_pop = 1'b0;
        repeat (2) @(negedge clk_sys);
    endtask
    task automatic push(input logic [DATA_W-1:0] d);
        ofifo_data = d;
        ofifo_push = 1'b1;
        @(negedge clk_sys);
        ofifo_push = 1'b0;
        ofifo_data = ~d;
        @(negedge clk_sys);
    endtask

    ////////////////////////////////////////
    // scenarios
    task automatic t_reset();
        sys_rst = 1'b1;
        unit_rdata = '0;
        ififo_pop = 1'b0;
        ofifo_push = 1'b0;
        ofifo_data = '0;
        repeat (3) @(posedge clk_sys);
        check(ack_n === 1'b1 && wait_hi === 1'b0 && oe === 1'b0, "in reset");
        @(negedge clk_sys);
        sys_rst = 1'b0;
        check(ififo_level === '0 && ofifo_level === '0, "levels");
    endtask
    task automatic t_m1_fifo();
        host.wbuf[0] = 32'h1234_5678;
        run(1'b0, 1'b0, 12'h005, 1, LFIX); // write
        pop_chk(32'h1234_5678);
        push(32'h9ABC_DEF0);
        run(1'b0, 1'b1, 12'h400, 1, LFIX); // read
        check(host.rbuf[0] === 32'h9ABC_DEF0, "ofifo read");
        run(1'b0, 1'b1, 12'h400, 1, LFIX); // empty fifo
        check(host.rbuf[0] === 32'h0000_0000, "empty read");
    endtask
    task automatic t_m1_unit();
        host.wbuf[0] = 32'h0BAD_F00D;
        run(1'b0, 1'b0, 12'hC10, 1, LUNIT); // strobe low
        check(uw_cnt == 1 && uw_addr === 12'hC10 && uw_data === 32'h0BAD_F00D, "uwr");
        unit_rdata = 32'h5555_AAAA;
        run(1'b0, 1'b1, 12'hC20, 1, LUNIT);
        check(host.rbuf[0] === 32'h5555_AAAA && ur_cnt == 1, "urd");
    endtask
    task automatic t_m1_nostart();
        host.sel_n_o = 1'b0;
        repeat (8) begin
            @(negedge clk_sys);
            check(ack_n === 1'b1 && oe === 1'b0, "no start");
        end
        host.sel_n_o = 1'b1;
        @(negedge clk_sys);
    endtask
    task automatic t_m2_fixed();
        host.wbuf[0] = 32'hCAFE_0001;
        run(1'b1, 1'b0, 12'h001, 1, LFIX); // no strobe
        pop_chk(32'hCAFE_0001);
        push(32'hCAFE_0002);
        run(1'b1, 1'b1, 12'h402, 1, LFIX);
        check(host.rbuf[0] === 32'hCAFE_0002, "m2 read");
    endtask
    task automatic t_m2_unit();
        host.wbuf[0] = 32'h3C3C_C3C3;
        run(1'b1, 1'b0, 12'hC44, 1, LUNIT);
        check(uw_cnt == 2 && uw_data === 32'h3C3C_C3C3, "m2 uwr");
        unit_rdata = 32'h7E7E_8181;
        run(1'b1, 1'b1, 12'hC48, 1, LUNIT);
        check(host.rbuf[0] === 32'h7E7E_8181, "m2 urd");
    endtask
    // interface registers: written in one mode, read back in the other
    task automatic t_ifreg();
        host.wbuf[0] = 32'h5A5A_0F0F;
        run(1'b0, 1'b0, 12'h802, 1, LFIX);
        run(1'b1, 1'b1, 12'h802, 1, LFIX);
        check(host.rbuf[0] === 32'h5A5A_0F0F, "ifreg read");
        run(1'b0, 1'b1, 12'h801, 1, LFIX);
        check(host.rbuf[0] === RD_RESET, "ifreg other");
    endtask
    task automatic t_m2_burst();
        for (int i = 0; i < 4; i++) host.wbuf[i] = 32'hB000_0000 + i;
        run(1'b1, 1'b0, 12'h000, 4, LBUR);
        check(ififo_level === 8'h04, "burst level");
        for (int i = 0; i < 4; i++) pop_chk(32'hB000_0000 + i);
        for (int i = 0; i < 4; i++) push(32'hD000_0000 + i);
        check(ofifo_level === 8'h04, "ofifo level");
        run(1'b1, 1'b1, 12'h400, 4, LBUR);
        for (int i = 0; i < 4; i++) begin
            check(host.rbuf[i] === 32'hD000_0000 + i, "brd");
        end
        check(ofifo_level === 8'h00, "ofifo drained");
    endtask
    // reset in the middle of a second-mode wait, with the port selected
    task automatic t_mid_reset();
        host.mode_o = 1'b1;
        host.sel_n_o = 1'b0;
        repeat (2) @(negedge clk_sys);
        check(wait_hi === 1'b1, "m2 wait");
        sys_rst = 1'b1;
        host.sel_n_o = 1'b1;
        @(negedge clk_sys);
        check(wait_hi === 1'b0 && ack_n === 1'b1 && oe === 1'b0, "mid reset");
        sys_rst = 1'b0;
        repeat (2) @(negedge clk_sys);
        idle_chk();
    endtask

    ////////////////////////////////////////
    // main sequence, then a watchdog far beyond the roughly 160 cycles needed
    initial begin
        t_reset();
        t_m1_fifo();
        t_m1_unit();
        t_m1_nostart();
        t_m2_fixed();
        t_m2_unit();
        t_ifreg();
        t_m2_burst();
        t_mid_reset();
        conclude();
    end
    initial begin
        #50000;
        mismatches++;
        conclude();
    end
endmodule
